/* tfp_map.svh */
`ifndef TFP_MAP_SVH
`define TFP_MAP_SVH

// length of the forced full-drive interval, in time-base periods
`define TFP_STARTUP_PERIODS 7'h40
// last count value of the startup interval
`define TFP_STARTUP_LAST 7'h3f
// width of the startup counter
`define TFP_STARTUP_CNT_W 7
// stages in the flag synchroniser
`define TFP_SYNC_STAGES 2
// output register values after reset: fan low, fault released
`define TFP_RST_FAN_DRIVE 1'h0
`define TFP_RST_FAULT_N 1'h1

`endif

/* tfp_pkg.sv */
package tfp_pkg;

  // comparator flags from the analog front end, all active high
  typedef struct packed {
    logic sleep_input_grounded; // sleep threshold pin tied to ground
    logic t1_above_sleep;       // primary above sleep threshold
    logic t2_above_sleep;       // secondary above sleep threshold
    logic t1_above_wake;        // primary above sleep threshold plus hysteresis
    logic t2_above_wake;        // secondary above sleep threshold plus hysteresis
    logic t1_above_full;        // primary above full-duty threshold
    logic t1_above_fault;       // primary above fault threshold
    logic pwm_t1_high;          // triangle below primary input
    logic pwm_t2_high;          // triangle below secondary input
  } tfp_flags_t;

  // fan drive and fault pins, each as value plus output enable
  typedef struct packed {
    logic fan_drive;
    logic fan_drive_oe;
    logic overtemp_fault_n;
    logic overtemp_fault_n_oe;
  } tfp_pins_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    TFP_ST_IDLE  = 4'h1,
    TFP_ST_START = 4'h2,
    TFP_ST_RUN   = 4'h4,
    TFP_ST_SLEEP = 4'h8
  } tfp_state_t;

endpackage

/* tfp_rst_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// shutdown/reset generator: asserts at once when the primary input drops
// below the shutdown level, releases only after it is seen above the
// startup level, so the band between the two levels cannot chatter
module tfp_rst_sync (
  input wire logic clk,                // time base
  input wire logic rst_n,              // power-on reset
  input wire logic t1_above_shutdown,  // primary above shutdown threshold
  input wire logic t1_above_startup,   // primary above startup threshold
  output logic sys_rst_n               // internal reset, active low
);

  wire arst_n;
  logic meta_reg;
  logic sync_reg;
  logic rel_reg;

  // shutdown needs no clock, it is folded into the asynchronous reset
  assign arst_n = rst_n & t1_above_shutdown;

  // startup level crosses two flops, then the release latches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'h0;
      sync_reg <= 1'h0;
      rel_reg <= 1'h0;
    end else begin
      meta_reg <= t1_above_startup;
      sync_reg <= meta_reg;
      rel_reg <= rel_reg | sync_reg;
    end
  end

  assign sys_rst_n = rel_reg;

endmodule

`default_nettype wire

/* tfp_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tfp_map.svh"

module tfp_seq (
  input wire logic clk,                     // internal time base, one PWM period each
  input wire logic rst_n,                   // power-on reset
  input wire logic t1_above_shutdown,       // primary above shutdown level, async
  input wire logic t1_above_startup,        // primary above startup level
  input wire tfp_pkg::tfp_flags_t cmp_flags, // comparator flags, unsynchronised
  output tfp_pkg::tfp_pins_t pins           // fan drive and fault pin controls
);

  // internal reset combines power-on and shutdown
  wire sys_rst_n;

  tfp_rst_sync u_rst (
    .clk(clk),
    .rst_n(rst_n),
    .t1_above_shutdown(t1_above_shutdown),
    .t1_above_startup(t1_above_startup),
    .sys_rst_n(sys_rst_n)
  );

  // two-flop synchroniser for the comparator flags; the first stage is
  // read only by the second, so a metastable value never reaches logic
  tfp_pkg::tfp_flags_t flags_meta_reg;
  tfp_pkg::tfp_flags_t flags_reg;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      flags_meta_reg <= '0;
      flags_reg <= '0;
    end else begin
      flags_meta_reg <= cmp_flags;
      flags_reg <= flags_meta_reg;
    end
  end

  // decoded conditions
  wire above_wake;
  wire both_below_sleep;
  wire sleep_req;
  wire pwm_high;
  wire force_full;
  wire fault_now;

  // wake when either input clears sleep threshold plus hysteresis
  assign above_wake = flags_reg.t1_above_wake | flags_reg.t2_above_wake;
  // both inputs must be low; one alone keeps the fan running
  assign both_below_sleep = ~flags_reg.t1_above_sleep & ~flags_reg.t2_above_sleep;
  // a grounded sleep pin disables sleep outright
  assign sleep_req = both_below_sleep & ~flags_reg.sleep_input_grounded;
  // the higher input wins: its compare is high whenever either one is
  assign pwm_high = flags_reg.pwm_t1_high | flags_reg.pwm_t2_high;
  // fault sits above full duty, so the fault term only covers
  // comparator offsets and never changes the duty on its own
  assign force_full = flags_reg.t1_above_full | flags_reg.t1_above_fault;
  assign fault_now = flags_reg.t1_above_fault;

  // state and startup counter
  tfp_pkg::tfp_state_t state_reg;
  tfp_pkg::tfp_state_t state_next;
  logic [`TFP_STARTUP_CNT_W-1:0] cnt_reg;
  logic [`TFP_STARTUP_CNT_W-1:0] cnt_next;
  wire start_done;

  assign start_done = (cnt_reg == `TFP_STARTUP_LAST);

  // next-state logic; each state is one period of the time base
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tfp_pkg::TFP_ST_IDLE: begin
        // after reset the fan stays off until an input is warm enough
        if (above_wake) begin
          state_next = tfp_pkg::TFP_ST_START;
        end
      end
      tfp_pkg::TFP_ST_START: begin
        if (start_done) begin
          state_next = tfp_pkg::TFP_ST_RUN;
        end
      end
      tfp_pkg::TFP_ST_RUN: begin
        if (sleep_req) begin
          state_next = tfp_pkg::TFP_ST_SLEEP;
        end
      end
      tfp_pkg::TFP_ST_SLEEP: begin
        if (above_wake) begin
          state_next = tfp_pkg::TFP_ST_START;
        end
      end
      default: begin
        state_next = tfp_pkg::TFP_ST_IDLE;
      end
    endcase
  end

  // counter runs only in the startup state and restarts on every entry
  // it shows the full count for one period after startup, then clears
  assign cnt_next = (state_reg == tfp_pkg::TFP_ST_START) ?
                    cnt_reg + `TFP_STARTUP_CNT_W'(1) : '0;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_reg <= tfp_pkg::TFP_ST_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // pin controls, decoded from the current state
  tfp_pkg::tfp_pins_t pins_next;
  wire in_idle;
  wire in_start;
  wire in_run;
  wire in_sleep;

  assign in_idle = (state_reg == tfp_pkg::TFP_ST_IDLE);
  assign in_start = (state_reg == tfp_pkg::TFP_ST_START);
  assign in_run = (state_reg == tfp_pkg::TFP_ST_RUN);
  assign in_sleep = (state_reg == tfp_pkg::TFP_ST_SLEEP);

  // idle drives the fan low; sleep lets it float to save current
  assign pins_next.fan_drive = in_start | (in_run & (force_full | pwm_high));
  assign pins_next.fan_drive_oe = ~in_sleep;
  // fault is open drain: enable while pulling low, value low only while enabled
  assign pins_next.overtemp_fault_n_oe = (in_start | in_run) & fault_now;
  assign pins_next.overtemp_fault_n = ~((in_start | in_run) & fault_now);

  // outputs are registered; shutdown clears them at once, so both pins
  // float without waiting for a time-base edge that may be 30 ms away
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pins.fan_drive <= `TFP_RST_FAN_DRIVE;
      pins.fan_drive_oe <= 1'h0;
      pins.overtemp_fault_n <= `TFP_RST_FAULT_N;
      pins.overtemp_fault_n_oe <= 1'h0;
    end else begin
      pins <= pins_next;
    end
  end

  // checks, all on the time base, all but the shutdown check under the internal reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!sys_rst_n);

  sequence seq_enter_start;
    (state_reg != tfp_pkg::TFP_ST_START) ##1 (state_reg == tfp_pkg::TFP_ST_START);
  endsequence

  sequence seq_hold_start;
    (state_reg == tfp_pkg::TFP_ST_START) [*8];
  endsequence

  sequence seq_sleep_wake;
    (state_reg == tfp_pkg::TFP_ST_SLEEP) && above_wake;
  endsequence

  AST_START_HOLD: assert property (
    seq_enter_start |-> seq_hold_start ##1 (pins.fan_drive && pins.fan_drive_oe))
    else $error("startup interval shorter than expected");

  AST_START_LEN: assert property (
    (in_start && cnt_reg == `TFP_STARTUP_LAST) |=> in_run ##1 (cnt_reg == '0))
    else $error("startup interval did not end after 64 periods");

  AST_START_DRIVE: assert property (
    in_start |=> (pins.fan_drive && pins.fan_drive_oe))
    else $error("fan not forced high during startup");

  AST_WAKE_RESTART: assert property (
    seq_sleep_wake |=> (in_start && cnt_reg == '0))
    else $error("wake did not restart the startup timer");

  AST_SLEEP_STAY: assert property (
    (in_sleep && !above_wake) |=> in_sleep ##1 !pins.fan_drive_oe)
    else $error("sleep left without wake condition");

  AST_RUN_PWM: assert property (
    (in_run && !force_full) |=> (pins.fan_drive == $past(pwm_high)))
    else $error("fan drive does not follow the higher input");

  AST_RUN_FULL: assert property (
    (in_run && flags_reg.t1_above_full) |=> (pins.fan_drive && pins.fan_drive_oe))
    else $error("full-duty threshold did not force high drive");

  AST_FAULT_SET: assert property (
    ((in_run || in_start) && fault_now) |=> (pins.overtemp_fault_n_oe && !pins.overtemp_fault_n))
    else $error("fault output not asserted");

  AST_FAULT_CLEAR: assert property (
    !fault_now |=> (!pins.overtemp_fault_n_oe && pins.overtemp_fault_n))
    else $error("fault output held after threshold dropped");

  AST_FAULT_FULL: assert property (
    pins.overtemp_fault_n_oe |-> (pins.fan_drive && pins.fan_drive_oe))
    else $error("fault active without full drive");

  AST_SLEEP_ENTER: assert property (
    (in_run && sleep_req) |=> in_sleep ##1 (!pins.fan_drive_oe && !pins.overtemp_fault_n_oe))
    else $error("sleep not entered or pins still driven");

  AST_NO_SLEEP_ONE: assert property (
    (in_run && !both_below_sleep) |=> !in_sleep)
    else $error("sleep entered with one input still above threshold");

  AST_SLEEP_GND: assert property (
    (!in_sleep && flags_reg.sleep_input_grounded) |=> !in_sleep)
    else $error("sleep entered with sleep input grounded");

  AST_IDLE_WAIT: assert property (
    (in_idle && !above_wake) |=> in_idle ##1 (!pins.fan_drive && pins.fan_drive_oe))
    else $error("fan started without wake condition");

  // exact length of the forced interval: entry, 63 more periods, then run
  sequence seq_start_to_run;
    in_start ##63 (in_start && start_done) ##1 in_run;
  endsequence

  AST_START_EXACT: assert property (
    seq_enter_start |-> seq_start_to_run)
    else $error("startup interval not exactly 64 periods");

  // a sleep request during startup is ignored until run
  AST_START_STAY: assert property (
    (in_start && !start_done) |=> in_start)
    else $error("startup interval cut short");

  AST_CNT_BOUND: assert property (
    cnt_reg <= `TFP_STARTUP_PERIODS)
    else $error("startup counter ran past its end");

  // the counter must sit at zero wherever a startup can begin
  AST_CNT_CLEAR: assert property (
    (in_idle || in_sleep) |-> (cnt_reg == '0))
    else $error("startup counter not cleared before startup");

  // run is left only for sleep; shutdown acts through the reset
  AST_RUN_STAY: assert property (
    (in_run && !sleep_req) |=> in_run)
    else $error("normal operation left without sleep request");

  // a corrupted state word would leave every pin decode false
  AST_STATE_ONEHOT: assert property (
    $onehot(state_reg))
    else $error("state register not one-hot");

  // pin levels per state; idle drives the fan low, sleep floats both
  AST_IDLE_PINS: assert property (
    in_idle |=> (!pins.fan_drive && pins.fan_drive_oe && !pins.overtemp_fault_n_oe))
    else $error("fan or fault driven while waiting for wake");

  AST_SLEEP_PINS: assert property (
    in_sleep |=> (!pins.fan_drive_oe && !pins.overtemp_fault_n_oe))
    else $error("pins still driven during sleep");

  // open drain: the pin is only ever enabled to pull low
  AST_FAULT_PULL: assert property (
    pins.overtemp_fault_n_oe |-> !pins.overtemp_fault_n)
    else $error("fault pin driven high");

  AST_FAULT_CAUSE: assert property (
    pins.overtemp_fault_n_oe |-> $past(fault_now))
    else $error("fault pin asserted without a fault");

  // shutdown acts without the clock, so this one is not disabled by the
  // internal reset; the pins must already float when the edge samples them
  AST_SHUTDOWN_FLOAT: assert property (
    @(posedge clk) disable iff (1'h0)
    !sys_rst_n |-> (!pins.fan_drive_oe && !pins.overtemp_fault_n_oe))
    else $error("pins driven during shutdown");

endmodule

`default_nettype wire

/* tfp_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// sensors, comparators and fault pull-up around the logic; levels in percent of supply
module tfp_far_side (
  input wire logic clk, // time base
  input wire logic [7:0] t1_pct, // primary level
  input wire logic [7:0] t2_pct, // secondary level
  input wire logic [7:0] slp_pct, // sleep threshold, 0 = grounded
  input wire tfp_pkg::tfp_pins_t pins, // pin controls from the logic
  output tfp_pkg::tfp_flags_t flags, // comparator flags
  output logic t1_above_shutdown, // primary above shutdown level
  output logic t1_above_startup, // primary above startup level
  output logic fault_line // fault wire with its pull-up
);
  logic [2:0] phase_reg = 3'h0;
  logic [7:0] tri_pct;
  logic [7:0] wake_pct;

  // triangle steps once a period, so eight periods give an exact duty
  always_ff @(posedge clk) begin
    phase_reg <= phase_reg + 3'h1;
  end

  // comparators; shutdown and startup levels differ to give hysteresis
  assign tri_pct = 8'h1e + 8'(phase_reg) * 8'h05;
  assign wake_pct = slp_pct + 8'h0b;
  assign flags.sleep_input_grounded = (slp_pct == 8'h00);
  // the sleep comparators carry a small offset, so inputs just above a
  // grounded sleep pin still read as below it
  assign flags.t1_above_sleep = t1_pct > slp_pct + 8'h05;
  assign flags.t2_above_sleep = t2_pct > slp_pct + 8'h05;
  assign flags.t1_above_wake = t1_pct > wake_pct;
  assign flags.t2_above_wake = t2_pct > wake_pct;
  assign flags.t1_above_full = t1_pct > 8'h46;
  assign flags.t1_above_fault = t1_pct > 8'h4d;
  assign flags.pwm_t1_high = t1_pct > tri_pct;
  assign flags.pwm_t2_high = t2_pct > tri_pct;
  assign t1_above_shutdown = t1_pct > 8'h04;
  assign t1_above_startup = t1_pct > 8'h08;
  // open drain: a released pin reads high
  assign fault_line = (pins.overtemp_fault_n_oe && !pins.overtemp_fault_n) ? 1'h0 : 1'h1;
endmodule

`default_nettype wire

/* test_thermal_fan_pwm_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_thermal_fan_pwm_sequencer;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] t1_pct = 8'h0f;
  logic [7:0] t2_pct = 8'h00;
  logic [7:0] slp_pct = 8'h0a;
  logic above_sd;
  logic above_su;
  logic fault_line;
  tfp_pkg::tfp_flags_t flags;
  tfp_pkg::tfp_pins_t pins;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;

  tfp_seq u_dut (.clk(clk), .rst_n(rst_n), .t1_above_shutdown(above_sd),
    .t1_above_startup(above_su), .cmp_flags(flags), .pins(pins));
  tfp_far_side u_far (.clk(clk), .t1_pct(t1_pct), .t2_pct(t2_pct), .slp_pct(slp_pct),
    .pins(pins), .flags(flags), .t1_above_shutdown(above_sd), .t1_above_startup(above_su),
    .fault_line(fault_line));

  always #4 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang is cut short well beyond the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 9000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // new levels at a rising edge, then let the sync pipeline settle
  task automatic set_lv(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
    @(posedge clk);
    t1_pct <= a;
    t2_pct <= b;
    slp_pct <= s;
    repeat (8) @(negedge clk);
  endtask

  // high periods over 64 periods, a whole number of triangle sweeps
  task automatic duty(output int hi);
    hi = 0;
    repeat (64) begin
      @(negedge clk);
      if (pins.fan_drive === 1'h1) hi++;
    end
  endtask

  // length of the next run of forced-high drive
  task automatic run_len(output int len);
    int w;
    len = 0;
    w = 0;
    while (pins.fan_drive !== 1'h1 && w < 16) begin
      @(negedge clk);
      w++;
    end
    while (pins.fan_drive === 1'h1 && len < 100) begin
      @(negedge clk);
      len++;
    end
  endtask

  task automatic test_power_up();
    check(8'(pins.fan_drive), 8'h00);
    check(8'(pins.fan_drive_oe), 8'h01);
    @(posedge clk);
    t1_pct <= 8'h19;
    run_len(n);
    check(8'(n), 8'h40);
    check(8'(pins.fan_drive), 8'h00);
    set_lv(8'h3c, 8'h00, 8'h0a);
    duty(n);
    check(8'(n), 8'h30);
    $display("power-up done");
  endtask

  task automatic test_higher();
    set_lv(8'h2d, 8'h3e, 8'h0a);
    duty(n);
    check(8'(n), 8'h38);
    set_lv(8'h3e, 8'h2d, 8'h0a);
    duty(n);
    check(8'(n), 8'h38);
    $display("higher input done");
  endtask

  task automatic test_fault();
    set_lv(8'h50, 8'h00, 8'h0a);
    check(8'(pins.overtemp_fault_n_oe), 8'h01);
    check(8'(fault_line), 8'h00);
    duty(n);
    check(8'(n), 8'h40);
    set_lv(8'h48, 8'h00, 8'h0a);
    check(8'(fault_line), 8'h01);
    duty(n);
    check(8'(n), 8'h40);
    set_lv(8'h32, 8'h00, 8'h0a);
    duty(n);
    check(8'(n), 8'h20);
    $display("fault done");
  endtask

  task automatic test_sleep();
    set_lv(8'h0a, 8'h32, 8'h0f);
    duty(n);
    check(8'(n), 8'h20);
    set_lv(8'h0a, 8'h0a, 8'h0f);
    check(8'(pins.fan_drive_oe), 8'h00);
    check(8'(pins.overtemp_fault_n_oe), 8'h00);
    set_lv(8'h18, 8'h0a, 8'h0f);
    check(8'(pins.fan_drive_oe), 8'h00);
    @(posedge clk);
    t1_pct <= 8'h1c;
    run_len(n);
    check(8'(n), 8'h40);
    $display("sleep done");
  endtask

  task automatic test_ground_and_shutdown();
    // both inputs read below a grounded sleep pin, yet the fan drive stays enabled instead of floating
    set_lv(8'h05, 8'h05, 8'h00);
    repeat (12) @(negedge clk);
    check(8'(pins.fan_drive_oe), 8'h01);
    @(posedge clk);
    t1_pct <= 8'h02;
    #1;
    check(8'(pins), 8'h02);
    repeat (3750) @(posedge clk);
    t1_pct <= 8'h0f;
    run_len(n);
    check(8'(n), 8'h40);
    $display("shutdown done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (16) @(negedge clk);
    test_power_up();
    test_higher();
    test_fault();
    test_sleep();
    test_ground_and_shutdown();
    give_verdict();
  end
endmodule

`default_nettype wire
